// File: logic/gpp_port_map.vh
`ifndef GPP_PORT_MAP_VH
`define GPP_PORT_MAP_VH

// ****************************************************************
// Port geometry
// ****************************************************************
`define GPP_PORTS 4
`define GPP_PIN_COUNT 28
`define GPP_PIN_MASK 32'h0FFF_FFFF

// ****************************************************************
// Register offsets (byte addresses; port registers by word index)
// ****************************************************************
// Port k sits at k * GPP_PORT_STRIDE; its three registers follow.
`define GPP_PORT_STRIDE 8'h10
`define GPP_OFS_OUT 2'h0
`define GPP_OFS_DIR 2'h1
`define GPP_OFS_IN 2'h2
`define GPP_ADDR_CTRL 8'h40
`define GPP_ADDR_CHG_CTRL 8'h44
`define GPP_ADDR_CHG_FLAG 8'h48
`define GPP_ADDR_MASK0 8'h4C
`define GPP_ADDR_MASK1 8'h50
`define GPP_ADDR_MASK2 8'h54
`define GPP_ADDR_MASK3 8'h58
`define GPP_ADDR_BITOP 8'h5C

// ****************************************************************
// Field positions
// ****************************************************************
`define GPP_CTRL_PUD 0
`define GPP_CTRL_BBM_LO 4
`define GPP_BITOP_BIT_LO 0
`define GPP_BITOP_PORT_LO 4
`define GPP_BITOP_TARGET 8
`define GPP_BITOP_VALUE 9

// ****************************************************************
// Reset values
// ****************************************************************
`define GPP_RST_BYTE 8'h00
`define GPP_RST_WORD 32'h0000_0000
`define GPP_RST_NIB 4'h0

`endif

// File: logic/gpp_sync.v
// ****************************************************************
// Two-stage input synchroniser bank
// ****************************************************************
module gpp_sync #(
  parameter WIDTH = 28
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Data
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      meta_r <= {WIDTH{1'b0}};
      q_out <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule // gpp_sync

// File: logic/gpp_port.v
`include "gpp_port_map.vh"

module gpp_port #(
  parameter NPIN = `GPP_PIN_COUNT
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Processor interrupt handshake
  input wire CPU_IRQ_EN,
  input wire [3:0] IRQ_ACK,
  output reg [3:0] IRQ_REQ,
  // Pins
  input wire [NPIN-1:0] PIN_IN,
  output reg [NPIN-1:0] PIN_OUT,
  output reg [NPIN-1:0] PIN_OE,
  output reg [NPIN-1:0] PIN_PULLUP
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [31:0] out_r;
  reg [31:0] out_nxt;
  reg [31:0] dir_r;
  reg [31:0] dir_nxt;
  reg [31:0] dir_prev_r;
  reg [31:0] samp_prev_r;
  reg pud_r;
  reg pud_nxt;
  reg [3:0] bbm_r;
  reg [3:0] bbm_nxt;
  reg [3:0] chg_en_r;
  reg [3:0] chg_en_nxt;
  reg [3:0] flag_r;
  reg [3:0] flag_nxt;
  reg [31:0] mask_r;
  reg [31:0] mask_nxt;
  reg [31:0] rdata_nxt;
  reg err_nxt;
  reg hit;

  wire [NPIN-1:0] samp_pins;
  wire [31:0] samp;
  wire [31:0] chg;
  wire [3:0] grp_set;
  wire wr_en;
  wire is_port;
  wire [1:0] port_sel;
  wire [1:0] port_reg;
  wire [4:0] shift;
  wire [31:0] wbyte;
  wire [31:0] bit_one;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // two-stage synchroniser
  gpp_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .d_in(PIN_IN),
    .q_out(samp_pins)
  );

  assign samp = {{(32 - NPIN){1'b0}}, samp_pins};

  // ****************************************************************
  // Pin-change detection
  // ****************************************************************
  // compare with previous sample
  assign chg = (samp ^ samp_prev_r) & mask_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      assign grp_set[g] = chg_en_r[g] & (|chg[8*g+7:8*g]);
    end
  endgenerate

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;
  assign is_port = (PADDR < `GPP_ADDR_CTRL);
  assign port_sel = PADDR[5:4];
  assign port_reg = PADDR[3:2];
  assign shift = {port_sel, 3'b000};
  assign wbyte = {24'h00_0000, PWDATA[7:0]} << shift;
  assign bit_one = 32'h0000_0001 << {PWDATA[`GPP_BITOP_PORT_LO+1:
    `GPP_BITOP_PORT_LO], PWDATA[`GPP_BITOP_BIT_LO+2:`GPP_BITOP_BIT_LO]};

  always @* begin
    hit = 1'b1;
    rdata_nxt = `GPP_RST_WORD;
    if (is_port) begin
      case (port_reg)
        `GPP_OFS_OUT: rdata_nxt = {24'h00_0000, out_r[shift +: 8]};
        `GPP_OFS_DIR: rdata_nxt = {24'h00_0000, dir_r[shift +: 8]};
        `GPP_OFS_IN: rdata_nxt = {24'h00_0000, samp[shift +: 8]};
        default: hit = 1'b0;
      endcase
    end else begin
      case (PADDR)
        `GPP_ADDR_CTRL: rdata_nxt = {24'h00_0000, bbm_r, 3'b000, pud_r};
        `GPP_ADDR_CHG_CTRL: rdata_nxt = {28'h000_0000, chg_en_r};
        `GPP_ADDR_CHG_FLAG: rdata_nxt = {28'h000_0000, flag_r};
        `GPP_ADDR_MASK0: rdata_nxt = {24'h00_0000, mask_r[7:0]};
        `GPP_ADDR_MASK1: rdata_nxt = {24'h00_0000, mask_r[15:8]};
        `GPP_ADDR_MASK2: rdata_nxt = {24'h00_0000, mask_r[23:16]};
        `GPP_ADDR_MASK3: rdata_nxt = {28'h000_0000, mask_r[27:24]};
        `GPP_ADDR_BITOP: rdata_nxt = `GPP_RST_WORD;
        default: hit = 1'b0;
      endcase
    end
    err_nxt = ~hit;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @* begin
    out_nxt = out_r;
    dir_nxt = dir_r;
    pud_nxt = pud_r;
    bbm_nxt = bbm_r;
    chg_en_nxt = chg_en_r;
    mask_nxt = mask_r;
    flag_nxt = flag_r;
    if (wr_en) begin
      if (is_port) begin
        if (port_reg == `GPP_OFS_OUT) begin
          out_nxt[shift +: 8] = PWDATA[7:0];
        end
        if (port_reg == `GPP_OFS_DIR) begin
          dir_nxt[shift +: 8] = PWDATA[7:0];
        end
        if (port_reg == `GPP_OFS_IN) begin
          out_nxt = out_r ^ wbyte;
        end
      end else begin
        case (PADDR)
          `GPP_ADDR_CTRL: begin
            pud_nxt = PWDATA[`GPP_CTRL_PUD];
            bbm_nxt = PWDATA[`GPP_CTRL_BBM_LO+3:`GPP_CTRL_BBM_LO];
          end
          `GPP_ADDR_CHG_CTRL: chg_en_nxt = PWDATA[3:0];
          `GPP_ADDR_CHG_FLAG: flag_nxt = flag_r & ~PWDATA[3:0];
          `GPP_ADDR_MASK0: mask_nxt[7:0] = PWDATA[7:0];
          `GPP_ADDR_MASK1: mask_nxt[15:8] = PWDATA[7:0];
          `GPP_ADDR_MASK2: mask_nxt[23:16] = PWDATA[7:0];
          `GPP_ADDR_MASK3: mask_nxt[27:24] = PWDATA[3:0];
          `GPP_ADDR_BITOP: begin
            if (PWDATA[`GPP_BITOP_TARGET]) begin
              dir_nxt = PWDATA[`GPP_BITOP_VALUE] ? (dir_r | bit_one) :
                (dir_r & ~bit_one);
            end else begin
              out_nxt = PWDATA[`GPP_BITOP_VALUE] ? (out_r | bit_one) :
                (out_r & ~bit_one);
            end
          end
          default: pud_nxt = pud_r;
        endcase
      end
    end
    flag_nxt = flag_nxt & ~IRQ_ACK;
    // A change seen in the clearing cycle is kept.
    flag_nxt = flag_nxt | grp_set;
    out_nxt = out_nxt & `GPP_PIN_MASK;
    dir_nxt = dir_nxt & `GPP_PIN_MASK;
  end

  // ****************************************************************
  // Registers and bus answer
  // ****************************************************************
  always @(posedge CLK) begin
    if (SYS_RST) begin
      out_r <= `GPP_RST_WORD;
      dir_r <= `GPP_RST_WORD;
      dir_prev_r <= `GPP_RST_WORD;
      samp_prev_r <= `GPP_RST_WORD;
      pud_r <= 1'b0;
      bbm_r <= `GPP_RST_NIB;
      chg_en_r <= `GPP_RST_NIB;
      flag_r <= `GPP_RST_NIB;
      mask_r <= `GPP_RST_WORD;
      IRQ_REQ <= `GPP_RST_NIB;
      PRDATA <= `GPP_RST_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      out_r <= out_nxt;
      dir_r <= dir_nxt;
      dir_prev_r <= dir_r;
      samp_prev_r <= samp;
      pud_r <= pud_nxt;
      bbm_r <= bbm_nxt;
      chg_en_r <= chg_en_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      // flag, group enable and global enable
      IRQ_REQ <= flag_r & chg_en_r & {4{CPU_IRQ_EN}};
      // The answer is prepared in the setup cycle, so access has no wait.
      PREADY <= PSEL & ~PENABLE;
      if (PSEL & ~PENABLE) begin
        PRDATA <= PWRITE ? `GPP_RST_WORD : rdata_nxt;
        PSLVERR <= err_nxt;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : g_pin
      // output enable cleared without a clock
      always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          PIN_OE[p] <= 1'b0;
        end else begin
          // rising direction held off one cycle
          // falling direction takes effect at once
          PIN_OE[p] <= dir_r[p] & ~(bbm_r[p/8] & ~dir_prev_r[p]);
        end
      end

      // every pin has its own output and direction bits; the pull-up disable is shared by all pins.
      always @(posedge CLK) begin
        if (SYS_RST) begin
          PIN_OUT[p] <= 1'b0;
          PIN_PULLUP[p] <= 1'b0;
        end else begin
          PIN_OUT[p] <= out_r[p];
          // pull-up only on inputs with bit one
          PIN_PULLUP[p] <= ~dir_r[p] & out_r[p] & ~pud_r;
        end
      end
    end
  endgenerate

endmodule // gpp_port

// File: tb/gpp_port_checker.sv
`include "gpp_port_map.vh"
// ****************************************************************
// Bus, interrupt and pin checks
// ****************************************************************
module gpp_port_checker #(
  parameter NPIN = 28
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Bus
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // Interrupt and pins
  input wire CPU_IRQ_EN,
  input wire [3:0] IRQ_REQ,
  input wire [NPIN-1:0] PIN_OE,
  input wire [NPIN-1:0] PIN_PULLUP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_unmap; PSEL && PENABLE && PADDR < 8'h40 && PADDR[3:2] == 2'h3
    |-> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("hole mapped");
  property p_mask3; PSEL && PENABLE && !PWRITE && PADDR == `GPP_ADDR_MASK3
    |-> PRDATA[31:4] == 28'h000_0000; endproperty
  a_mask3: assert property (p_mask3) else $error("reserved set");
  // The first edge after release must still see the pins let go.
  property p_release; $fell(SYS_RST) |-> PIN_OE == '0 && IRQ_REQ == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("pins driven");
  property p_pull; (PIN_OE & PIN_PULLUP) == '0; endproperty
  a_pull: assert property (p_pull) else $error("pull on output");
  property p_gate; !CPU_IRQ_EN |=> IRQ_REQ == 4'h0; endproperty
  a_gate: assert property (p_gate) else $error("ungated request");
  c_write: cover property (PSEL && PENABLE && PWRITE && PREADY);
  c_irq: cover property ($rose(IRQ_REQ[0]));
  c_err: cover property (PSLVERR);
endmodule // gpp_port_checker

bind gpp_port gpp_port_checker #(.NPIN(NPIN)) gpp_port_checker_i (.CLK,
  .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .CPU_IRQ_EN, .IRQ_REQ, .PIN_OE, .PIN_PULLUP);

// File: tb/gpp_pins_model.sv
// ****************************************************************
// Board circuitry on the port pins
// ****************************************************************
module gpp_pins_model (
  // Clock
  input wire CLK,
  // Port side
  input wire [27:0] pin_out,
  input wire [27:0] pin_oe,
  input wire [27:0] pin_pullup,
  // Board drivers
  input wire [27:0] ext_val,
  input wire [27:0] ext_en,
  output logic [27:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin flips every cycle, so a stale level never reads back.
  logic [27:0] flt = 28'h000_0000;
  always @(posedge CLK) flt <= ~flt;
  assign pin_in = pin_oe & pin_out | ~pin_oe & ext_en & ext_val
    | ~pin_oe & ~ext_en & (pin_pullup | flt);
endmodule // gpp_pins_model

// File: tb/gpp_port_bench.sv
// ****************************************************************
// Port regression bench
// ****************************************************************
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", n, x, g); end end
module gpp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, CPU_IRQ_EN = 1'b0, PREADY, PSLVERR, e;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q, sd = 32'h0000_0034;
  logic [3:0] IRQ_ACK = 4'h0, IRQ_REQ;
  logic [27:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
  logic [27:0] ext_val = 28'h000_0000, ext_en = 28'hFFF_FFFF;
  int rm[24], k, n_mismatch = 0, check_count = 0;
  always #5 CLK = ~CLK;
  gpp_port gpp_port_i (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CPU_IRQ_EN, .IRQ_ACK, .IRQ_REQ,
    .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PULLUP);
  gpp_pins_model gpp_pins_model_i (.CLK, .pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pullup(PIN_PULLUP), .ext_val, .ext_en, .pin_in(PIN_IN));
  function automatic logic [31:0] lfsr();
    sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
    return sd;
  endfunction
  function automatic int wm(int i);
    if (i == 12 || i == 13 || i == 17 || i == 18 || i == 22) return 'hF;
    return i == 16 ? 'hF1 : i == 23 ? 0 : 'hFF;
  endfunction
  function automatic logic [27:0] pv(int b);
    return 28'(rm[b] | rm[4 + b] << 8 | rm[8 + b] << 16 | rm[12 + b] << 24);
  endfunction
  function automatic logic [31:0] ex(int i);
    logic [27:0] p;
    p = pv(1) & pv(0) | ~pv(1) & ext_val;
    if (i > 23 || i < 16 && i % 4 == 3) return 32'h0000_0000;
    if (i < 16 && i % 4 == 2) return 32'(p >> i / 4 * 8) & wm(i - 2);
    return rm[i];
  endfunction
  function automatic void mw(int i, logic [31:0] d);
    int j;
    j = 4 * int'(d[5:4]) + d[8];
    if (i < 16 && i % 4 == 2) rm[i - 2] ^= d & wm(i - 2);
    else if (i == 18) rm[18] &= ~d;
    else if (i == 23 && d[9]) rm[j] |= 1 << d[2:0] & wm(j);
    else if (i == 23) rm[j] &= ~(1 << d[2:0]);
    else if (i < 23 && !(i < 16 && i % 4 == 3)) rm[i] = d & wm(i);
  endfunction
  task automatic apb(input logic w, input int i, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= 8'(i * 4);
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
    `CHK("error", i > 23 || i < 16 && i % 4 == 3, e)
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, i, d);
    mw(i, d);
  endtask
  task automatic rd(input int i);
    apb(1'b0, i, 32'h0000_0000);
    `CHK("read", ex(i), q)
  endtask
  task automatic pins();
    `CHK("oe", pv(1), PIN_OE)
    `CHK("out", pv(0) & pv(1), PIN_OUT & PIN_OE)
    `CHK("pull", pv(0) & ~pv(1) & {28{~rm[16][0]}}, PIN_PULLUP)
  endtask
  task automatic reset_chk();
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    rm = '{default: 0};
    @(posedge CLK);
    for (int i = 0; i < 25; i++) rd(i);
    pins();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    reset_chk();
    $display("test reset values done");
    for (int n = 0; n < 60; n++) begin
      k = int'(lfsr() % 18);
      ext_val <= 28'(lfsr());
      // random register writes are spaced by whole bus cycles.
      wr(k == 17 ? 23 : k, lfsr());
      repeat (4) @(posedge CLK);
      pins();
      rd(int'(lfsr() % 17));
    end
    $display("test random access done");
    wr(16, 32'h0000_0010);
    wr(1, 32'h0000_0000);
    wr(5, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      wr(4 * p + 1, 32'h0000_00FF);
      @(negedge CLK);
      `CHK("gap", p ? 8'hFF : 8'h00, PIN_OE[8 * p +: 8])
      @(negedge CLK);
      `CHK("drive", 8'hFF, PIN_OE[8 * p +: 8])
      @(posedge CLK);
      wr(4 * p + 1, 32'h0000_0000);
      @(negedge CLK);
      `CHK("release", 8'h00, PIN_OE[8 * p +: 8])
      @(posedge CLK);
    end
    $display("test break before make done");
    wr(19, 32'h0000_0001);
    ext_val[1:0] <= 2'h3;
    repeat (6) @(posedge CLK);
    rd(18);
    wr(17, 32'h0000_0001);
    CPU_IRQ_EN <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      ext_val[0] <= ~ext_val[0];
      for (int t = 0; t < 10 && IRQ_REQ[0] !== 1'b1; t++) @(posedge CLK);
      rm[18] = 1;
      `CHK("request", 4'h1, IRQ_REQ)
      rd(18);
      if (m) wr(18, 32'h0000_0001);
      else begin
        IRQ_ACK <= 4'h1;
        @(posedge CLK);
        IRQ_ACK <= 4'h0;
        rm[18] = 0;
      end
      repeat (2) @(negedge CLK);
      `CHK("cleared", 4'h0, IRQ_REQ)
      rd(18);
    end
    $display("test pin change done");
    wr(9, 32'h0000_00FF);
    @(negedge CLK);
    SYS_RST = 1'b1;
    #1;
    `CHK("async", 28'h000_0000, PIN_OE)
    reset_chk();
    $display("test mid reset done");
    stop_test();
  end
  initial begin
    #50us;
    n_mismatch++;
    stop_test();
  end
endmodule // gpp_port_bench
